/* File: rtl/capture_compare_status_control.sv */
// capture/compare trigger control and status unit with AHB-Lite slave
`default_nettype none
`include "cc_defines.svh"
// Function
// [R1] gate mode 10: gate fall sets capture disable
// [R2] arm bit arms one gate event, reads zero
// [R3] trigger status shows timer triggered and running
// [R4] set request triggers timer when trigger enabled
// [R5] clear request cancels trigger when trigger enabled
// [R6] shutdown flag reads one during shutdown event
// [R7] compare flag set on single-edge compare event
// [R8] capture disable blocks capture events
// [R9] overflow flag set when capture buffer overflows
// [R10] buffer-not-empty reads one while buffer holds data
// [R11] one-shot extended by programmed extra periods
// [R12] flags hold until cleared, writing one ignored
module capture_compare_status_control #(
   parameter int CAP_DEPTH = 4,
   parameter int TB_WIDTH = 16
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // unit pins, asynchronous to hclk
   input wire logic capture_in,
   input wire logic gate_in,
   input wire logic shutdown_in,
   // compare logic, same clock
   input wire logic compare_match,
   // unit outputs
   output logic irq,
   output logic trigger_active,
   output logic shutdown_active,
   output logic capture_strobe
);
   localparam int PW = $clog2(CAP_DEPTH);

   // ***********************************************
   // address decode
   // ***********************************************
   // used by the read mux path, the capture buffer pop and the data phase latch
   function automatic cc_pkg::reg_sel_t decode(input logic [7:0] a);
      case (a)
         `CC_OFF_CTRL1: decode = cc_pkg::SEL_CTRL1;
         `CC_OFF_CTRL2H: decode = cc_pkg::SEL_CTRL2H;
         `CC_OFF_CTRL3H: decode = cc_pkg::SEL_CTRL3H;
         `CC_OFF_STATL: decode = cc_pkg::SEL_STATL;
         `CC_OFF_STATH: decode = cc_pkg::SEL_STATH;
         `CC_OFF_PERIOD: decode = cc_pkg::SEL_PERIOD;
         `CC_OFF_CAPDAT: decode = cc_pkg::SEL_CAPDAT;
         `CC_OFF_INTST: decode = cc_pkg::SEL_INTST;
         `CC_OFF_INTMSK: decode = cc_pkg::SEL_INTMSK;
         default: decode = cc_pkg::SEL_NONE;
      endcase
   endfunction

   // ***********************************************
   // state
   // ***********************************************
   cc_pkg::bus_phase_t dp, next_dp; // data phase of the access
   logic [31:0] next_hrdata;
   logic [1:0] ctrl1, next_ctrl1; // trigger enable, one-shot
   logic [1:0] gmode, next_gmode; // capture gate mode
   logic [2:0] one_shot_extend_count, next_one_shot_extend_count; // one-shot extend count
   logic [TB_WIDTH-1:0] period, next_period;
   logic [`CC_INT_W-1:0] int_st, next_int_st;
   logic [`CC_INT_W-1:0] int_msk, next_int_msk;
   cc_pkg::flags_t flg, next_flg;
   logic arm, next_arm; // gate logic armed for one event
   cc_pkg::trig_state_t tstate, next_tstate;
   logic [2:0] os_left, next_os_left; // extra periods left
   logic [TB_WIDTH-1:0] tb, next_tb; // time base counter
   logic trig_en_d; // trigger enable one cycle ago
   logic [TB_WIDTH-1:0] cap_mem [CAP_DEPTH];
   logic [PW-1:0] wptr, rptr;
   logic [PW:0] cnt, next_cnt;
   // synchronisers: capture, gate, shutdown
   logic [2:0] sync1, sync2, prev;
   // prev starts at zero whatever the pins idle at: no edge until filled
   logic [2:0] warm;

   // ***********************************************
   // decoded events
   // ***********************************************
   logic aphase, wr_go, rd_pop, wr_stat, set_req, clr_req;
   logic cap_rise, gate_rise, gate_fall, shut_lvl, wrap;
   logic push, ovf, full, empty, os_end, running;
   logic cdis_set, cdis_clr;
   assign aphase = hsel & htrans[1] & hready;
   assign wr_go = dp.valid & dp.write;
   assign wr_stat = wr_go & (dp.sel == cc_pkg::SEL_STATL);
   assign set_req = wr_stat & hwdata[`CC_B_TSET];
   assign clr_req = wr_stat & hwdata[`CC_B_TCLR];
   assign cap_rise = warm[2] & sync2[0] & ~prev[0];
   assign gate_rise = warm[2] & sync2[1] & ~prev[1];
   assign gate_fall = warm[2] & ~sync2[1] & prev[1];
   assign shut_lvl = sync2[2];
   assign full = (cnt == (PW+1)'(CAP_DEPTH));
   assign empty = (cnt == '0);
   // blocked edges never reach the buffer
   assign push = cap_rise & ~flg.cdis & ~full; // R8
   assign ovf = cap_rise & ~flg.cdis & full; // R9
   assign rd_pop = aphase & ~hwrite & ~empty &
      (decode(haddr[7:0]) == cc_pkg::SEL_CAPDAT);
   assign running = (tstate != cc_pkg::TS_HOLD);
   assign wrap = running & (tb == period);
   assign os_end = (tstate == cc_pkg::TS_ONESHOT) & wrap &
      (os_left == 3'h0);
   assign cdis_set = arm & (gmode == `CC_GM_FALL) & gate_fall; // R1
   assign cdis_clr = arm & (gmode == `CC_GM_RISE) & gate_rise;

   // ***********************************************
   // pin synchronisers
   // ***********************************************
   // two flops before any logic looks at a pin, third for edges
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
         prev <= 3'h0;
         warm <= 3'h0;
      end else begin
         sync1 <= {shutdown_in, gate_in, capture_in};
         sync2 <= sync1;
         prev <= sync2;
         warm <= {warm[1:0], 1'b1};
      end
   end

   // ***********************************************
   // bus and register next values
   // ***********************************************
   always_comb begin
      next_dp = '{valid: aphase, write: hwrite,
                  sel: decode(haddr[7:0])};
      next_ctrl1 = ctrl1;
      next_gmode = gmode;
      next_one_shot_extend_count = one_shot_extend_count;
      next_period = period;
      next_int_msk = int_msk;
      next_hrdata = `CC_RST_WORD;
      // reads are muxed in the address phase, flopped for data phase
      if (aphase && !hwrite) begin
         case (decode(haddr[7:0]))
            cc_pkg::SEL_CTRL1:
               next_hrdata[`CC_B_TRIGGER_ENABLE:`CC_B_ONESHOT] = ctrl1;
            cc_pkg::SEL_CTRL2H: next_hrdata[`CC_B_GMODE] = gmode;
            cc_pkg::SEL_CTRL3H: next_hrdata[`CC_B_ONE_SHOT_EXTEND_COUNT] = one_shot_extend_count;
            cc_pkg::SEL_STATL: begin
               next_hrdata[`CC_B_ARM] = 1'b0; // R2
               next_hrdata[`CC_B_TRUN] = trigger_active; // R3
               next_hrdata[`CC_B_TSET] = 1'b0; // R4
               next_hrdata[`CC_B_TCLR] = 1'b0; // R5
               next_hrdata[`CC_B_SHUT] = flg.shut; // R6
               next_hrdata[`CC_B_CMP] = flg.cmp; // R7
               next_hrdata[`CC_B_CDIS] = flg.cdis;
               next_hrdata[`CC_B_COV] = flg.cov;
               next_hrdata[`CC_B_BNE] = ~empty; // R10
            end
            cc_pkg::SEL_PERIOD:
               next_hrdata[TB_WIDTH-1:0] = period;
            cc_pkg::SEL_CAPDAT:
               next_hrdata[TB_WIDTH-1:0] = cap_mem[rptr];
            cc_pkg::SEL_INTST:
               next_hrdata[`CC_INT_W-1:0] = int_st;
            cc_pkg::SEL_INTMSK:
               next_hrdata[`CC_INT_W-1:0] = int_msk;
            default: next_hrdata = `CC_RST_WORD; // status_high, unmapped
         endcase
      end
      // writes land in the data phase
      if (wr_go) begin
         case (dp.sel)
            cc_pkg::SEL_CTRL1:
               next_ctrl1 = hwdata[`CC_B_TRIGGER_ENABLE:`CC_B_ONESHOT];
            cc_pkg::SEL_CTRL2H: next_gmode = hwdata[`CC_B_GMODE];
            cc_pkg::SEL_CTRL3H: next_one_shot_extend_count = hwdata[`CC_B_ONE_SHOT_EXTEND_COUNT];
            cc_pkg::SEL_PERIOD:
               next_period = hwdata[TB_WIDTH-1:0];
            cc_pkg::SEL_INTMSK:
               next_int_msk = hwdata[`CC_INT_W-1:0];
            default: next_period = period;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp <= '0;
         hrdata <= `CC_RST_WORD;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         ctrl1 <= 2'h0;
         gmode <= 2'h0;
         one_shot_extend_count <= 3'h0;
         period <= TB_WIDTH'(`CC_RST_PERIOD);
         int_msk <= '0;
      end else begin
         dp <= next_dp;
         hrdata <= next_hrdata;
         hreadyout <= 1'b1; // zero wait states
         hresp <= 1'b0; // always OKAY
         ctrl1 <= next_ctrl1;
         gmode <= next_gmode;
         one_shot_extend_count <= next_one_shot_extend_count;
         period <= next_period;
         int_msk <= next_int_msk;
      end
   end

   // ***********************************************
   // trigger state and time base
   // ***********************************************
   // set beats clear when both requests come in one write
   always_comb begin
      next_tstate = tstate;
      next_os_left = os_left;
      next_tb = running ? (wrap ? '0 : tb + 1'b1) : '0;
      if (!ctrl1[1]) begin
         next_tstate = cc_pkg::TS_RUN; // no trigger: free running
      end else if (!trig_en_d) begin
         next_tstate = cc_pkg::TS_HOLD; // enable just set: wait
      end else if (set_req) begin
         next_tstate = ctrl1[0] ? cc_pkg::TS_ONESHOT
                                : cc_pkg::TS_RUN; // R4
         next_os_left = one_shot_extend_count; // R11
         next_tb = '0;
      end else if (clr_req) begin
         next_tstate = cc_pkg::TS_HOLD; // R5
      end else if (os_end) begin
         next_tstate = cc_pkg::TS_HOLD; // R11
      end else if (tstate == cc_pkg::TS_ONESHOT && wrap) begin
         next_os_left = os_left - 3'h1; // R11
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tstate <= cc_pkg::TS_HOLD;
         os_left <= 3'h0;
         tb <= '0;
         trig_en_d <= 1'b0;
         trigger_active <= 1'b0;
      end else begin
         tstate <= next_tstate;
         os_left <= next_os_left;
         tb <= next_tb;
         trig_en_d <= ctrl1[1];
         trigger_active <= (next_tstate != cc_pkg::TS_HOLD); // R3
      end
   end

   // ***********************************************
   // status flags, gate arm and interrupts
   // ***********************************************
   // a flag is cleared by writing zero; a new event wins the clear
   always_comb begin
      cc_pkg::flags_t clr;
      clr = '0;
      if (wr_stat) begin
         clr.shut = ~hwdata[`CC_B_SHUT];
         clr.cmp = ~hwdata[`CC_B_CMP];
         clr.cdis = ~hwdata[`CC_B_CDIS];
         clr.cov = ~hwdata[`CC_B_COV];
      end
      next_flg.shut = shut_lvl | (flg.shut & ~clr.shut); // R6 R12
      next_flg.cmp = compare_match | (flg.cmp & ~clr.cmp); // R7 R12
      next_flg.cov = ovf | (flg.cov & ~clr.cov); // R9 R12
      next_flg.cdis = cdis_set |
         (flg.cdis & ~clr.cdis & ~cdis_clr); // R1 R8
      next_arm = arm & ~(cdis_set | cdis_clr);
      // arming applies only in the two gating modes
      if (wr_stat && hwdata[`CC_B_ARM] &&
          (gmode == `CC_GM_RISE || gmode == `CC_GM_FALL)) begin
         next_arm = 1'b1; // R2
         // rising-edge gate holds capture off until its edge
         if (gmode == `CC_GM_RISE) begin
            next_flg.cdis = 1'b1;
         end
      end
      next_int_st = int_st;
      if (wr_go && dp.sel == cc_pkg::SEL_INTST) begin
         next_int_st = int_st & ~hwdata[`CC_INT_W-1:0];
      end
      next_int_st = next_int_st |
         {os_end, shut_lvl & ~flg.shut, compare_match, ovf, push};
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flg <= '0;
         arm <= 1'b0;
         int_st <= '0;
         irq <= 1'b0;
         shutdown_active <= 1'b0;
      end else begin
         flg <= next_flg;
         arm <= next_arm;
         int_st <= next_int_st;
         irq <= |(next_int_st & next_int_msk);
         shutdown_active <= next_flg.shut;
      end
   end

   // ***********************************************
   // capture buffer
   // ***********************************************
   // full buffer drops the new sample rather than the oldest
   always_comb begin
      next_cnt = cnt;
      case ({push, rd_pop})
         2'b10: next_cnt = cnt + 1'b1;
         2'b01: next_cnt = cnt - 1'b1;
         default: next_cnt = cnt;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= '0;
         wptr <= '0;
         rptr <= '0;
         capture_strobe <= 1'b0;
      end else begin
         cnt <= next_cnt;
         capture_strobe <= push; // R8
         if (push) begin
            wptr <= wptr + 1'b1;
         end
         if (rd_pop) begin
            rptr <= rptr + 1'b1;
         end
      end
   end

   // memory has no reset; occupancy count guards every pop, not the read data
   always_ff @(posedge hclk) begin
      if (push) begin
         cap_mem[wptr] <= tb;
      end
   end

   // ***********************************************
   // assertions
   // ***********************************************
   logic stat_rd;
   assign stat_rd = dp.valid & ~dp.write &
      (dp.sel == cc_pkg::SEL_STATL);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_GATE_FALL: assert property ( // R1
      cdis_set |=> flg.cdis ##1 !capture_strobe)
      else $error("gate fall did not disable capture");
   AST_ARM_ZERO: assert property ( // R2
      stat_rd |-> !hrdata[`CC_B_ARM] && !hrdata[`CC_B_TSET])
      else $error("write-only status bit read nonzero");
   AST_TRIG_STATUS: assert property ( // R3
      stat_rd |-> hrdata[`CC_B_TRUN] == $past(trigger_active))
      else $error("trigger status mismatch");
   AST_SET_REQ: assert property ( // R4
      set_req && ctrl1[1] && trig_en_d |=> trigger_active)
      else $error("set request did not trigger");
   AST_CLR_REQ: assert property ( // R5
      clr_req && !set_req && ctrl1[1] && trig_en_d
      |=> !trigger_active ##1 tb == '0)
      else $error("clear request did not stop timer");
   AST_SHUT: assert property ( // R6
      shut_lvl |=> shutdown_active)
      else $error("shutdown flag low during shutdown");
   AST_CMP: assert property ( // R7
      compare_match |=> flg.cmp)
      else $error("compare flag not set");
   AST_CDIS_BLOCK: assert property ( // R8
      flg.cdis && cap_rise && !rd_pop |=> !capture_strobe && $stable(cnt))
      else $error("capture while disabled");
   AST_OVF: assert property ( // R9
      cap_rise && !flg.cdis && full && !rd_pop |=> flg.cov && full)
      else $error("overflow not flagged");
   AST_BNE: assert property ( // R10
      stat_rd |-> hrdata[`CC_B_BNE] == ($past(cnt) != '0))
      else $error("buffer-not-empty mismatch");
   AST_ONESHOT_END: assert property ( // R11
      os_end && !set_req && ctrl1[1] |=> !trigger_active)
      else $error("one-shot did not end");
   AST_FLAG_HOLD: assert property ( // R12
      flg.cov && !(wr_stat && !hwdata[`CC_B_COV]) |=> flg.cov)
      else $error("overflow flag lost without clear");

   COV_ONESHOT: cover property (set_req && ctrl1[0] ##[1:40] os_end);
   COV_OVF: cover property (ovf);
   COV_GATE: cover property (cdis_set ##[1:20] cap_rise);
   COV_IRQ: cover property (push ##2 irq);
endmodule
`default_nettype wire

/* File: include/cc_defines.svh */
// register offsets, field positions and reset values of the unit
`ifndef CC_DEFINES_SVH
`define CC_DEFINES_SVH
// byte offsets, decoded on haddr[7:0]
`define CC_OFF_CTRL1 8'h00
`define CC_OFF_CTRL2H 8'h04
`define CC_OFF_CTRL3H 8'h08
`define CC_OFF_STATL 8'h0C
`define CC_OFF_STATH 8'h10
`define CC_OFF_PERIOD 8'h14
`define CC_OFF_CAPDAT 8'h18
`define CC_OFF_INTST 8'h1C
`define CC_OFF_INTMSK 8'h20
// field positions
`define CC_B_TRIGGER_ENABLE 7
`define CC_B_ONESHOT 6
`define CC_B_GMODE 7:6
`define CC_B_ONE_SHOT_EXTEND_COUNT 14:12
`define CC_B_ARM 10
`define CC_B_TRUN 7
`define CC_B_TSET 6
`define CC_B_TCLR 5
`define CC_B_SHUT 4
`define CC_B_CMP 3
`define CC_B_CDIS 2
`define CC_B_COV 1
`define CC_B_BNE 0
// gate modes
`define CC_GM_RISE 2'h1
`define CC_GM_FALL 2'h2
// reset values and interrupt field width
`define CC_RST_PERIOD 16'hFFFF
`define CC_RST_WORD 32'h00000000
`define CC_INT_W 5
`endif

/* File: include/cc_pkg.sv */
// types shared by the capture/compare status and control unit
`default_nettype none
package cc_pkg;
   // trigger state of the time base
   typedef enum logic [1:0] {
      TS_HOLD = 2'b00,
      TS_RUN = 2'b01,
      TS_ONESHOT = 2'b10
   } trig_state_t;
   // register selected by an access
   typedef enum logic [3:0] {
      SEL_NONE = 4'h0, SEL_CTRL1 = 4'h1, SEL_CTRL2H = 4'h2,
      SEL_CTRL3H = 4'h3, SEL_STATL = 4'h4, SEL_STATH = 4'h5,
      SEL_PERIOD = 4'h6, SEL_CAPDAT = 4'h7, SEL_INTST = 4'h8,
      SEL_INTMSK = 4'h9
   } reg_sel_t;
   // latched address phase of the bus
   typedef struct packed {
      logic valid;
      logic write;
      reg_sel_t sel;
   } bus_phase_t;
   // clearable flags of status_low
   typedef struct packed {
      logic shut;
      logic cmp;
      logic cdis;
      logic cov;
   } flags_t;
endpackage
`default_nettype wire

/* File: dv/capture_compare_status_control_bench.sv */
// self-checking bench for the capture/compare status and control unit
`default_nettype none
`include "cc_defines.svh"
module capture_compare_status_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // signals and design instance
   // ****************************************
   logic hclk, hresetn, hsel, hwrite, hready;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp;
   logic capture_in, gate_in, shutdown_in, compare_match;
   logic irq, trigger_active, shutdown_active, capture_strobe;
   int n_fail = 0; // mismatches seen
   int cmp_count = 0; // comparisons made
   logic [31:0] last_cap = 32'h00000000; // last captured time base
   // the one slave drives the bus ready
   assign hready = hreadyout;
   always #10 hclk = ~hclk;
   capture_compare_status_control uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .capture_in(capture_in), .gate_in(gate_in),
      .shutdown_in(shutdown_in), .compare_match(compare_match),
      .irq(irq), .trigger_active(trigger_active),
      .shutdown_active(shutdown_active), .capture_strobe(capture_strobe)
   );
   // ****************************************
   // checking and bus tasks
   // ****************************************
   task automatic summarize;
      if (n_fail == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk_word(string what, logic [31:0] exp, logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(string what, logic exp, logic got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask
   // let n edges pass, then sample where outputs have settled
   task automatic step(int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   // bounded wait for hready at a rising edge
   task automatic wait_rdy;
      int i;
      i = 0;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         i++;
         if (i > 50) begin
            $display("[FAIL] hready wait expected 1 seen %b", hready);
            n_fail++;
            summarize();
         end
         @(posedge hclk);
      end
   endtask
   task automatic bus_write(logic [7:0] off, logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= 1'b1;
      haddr <= {24'h000000, off};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask
   // read data is taken at the edge that ends the data phase
   task automatic bus_read(logic [7:0] off, output logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= 1'b0;
      haddr <= {24'h000000, off};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      wait_rdy();
      d = hrdata;
   endtask
   task automatic rd_chk(string what, logic [7:0] off, logic [31:0] exp);
      logic [31:0] d;
      bus_read(off, d);
      chk_word(what, exp, d);
   endtask
   // the time base free-runs here, so each capture is above the last
   task automatic cap_rd;
      logic [31:0] d;
      bus_read(`CC_OFF_CAPDAT, d);
      chk_bit("capdat", 1'b1, d > last_cap && d < 32'h00010000);
      last_cap = d;
   endtask
   // one capture edge, counting accepted capture strobes
   task automatic cap_pulse(output int n);
      n = 0;
      @(posedge hclk);
      capture_in <= 1'b1;
      repeat (6) begin
         step(1);
         if (capture_strobe === 1'b1) n++;
      end
      @(posedge hclk);
      capture_in <= 1'b0;
      step(4);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      rd_chk("status_low", `CC_OFF_STATL, 32'h00000080);
      rd_chk("status_high", `CC_OFF_STATH, 32'h00000000);
      rd_chk("period", `CC_OFF_PERIOD, 32'h0000FFFF);
      rd_chk("unmapped", 8'hF0, 32'h00000000);
      chk_bit("hresp", 1'b0, hresp);
   endtask
   task automatic t_capture;
      int n;
      bus_write(`CC_OFF_INTMSK, 32'h00000001);
      cap_pulse(n);
      chk_word("strobes", 32'h1, n);
      chk_bit("irq", 1'b1, irq);
      rd_chk("status_low", `CC_OFF_STATL, 32'h00000081);
      cap_rd();
      rd_chk("status_low", `CC_OFF_STATL, 32'h00000080);
      bus_write(`CC_OFF_INTST, 32'h00000001);
      step(2);
      chk_bit("irq", 1'b0, irq);
      // five edges into four places: the last is dropped
      for (int k = 0; k < 5; k++) begin
         cap_pulse(n);
         chk_word("strobes", (k < 4) ? 32'h1 : 32'h0, n);
      end
      rd_chk("status_low", `CC_OFF_STATL, 32'h00000083);
      bus_write(`CC_OFF_STATL, 32'h0000001E);
      rd_chk("status_low", `CC_OFF_STATL, 32'h00000083);
      bus_write(`CC_OFF_STATL, 32'h00000000);
      rd_chk("status_low", `CC_OFF_STATL, 32'h00000081);
      repeat (4) cap_rd();
      rd_chk("status_low", `CC_OFF_STATL, 32'h00000080);
      rd_chk("int_status", `CC_OFF_INTST, 32'h00000003);
      bus_write(`CC_OFF_INTST, 32'h0000001F);
      bus_write(`CC_OFF_INTMSK, 32'h00000000);
   endtask
   task automatic t_cmp_shut;
      @(posedge hclk);
      compare_match <= 1'b1;
      @(posedge hclk);
      compare_match <= 1'b0;
      step(3);
      rd_chk("status_low", `CC_OFF_STATL, 32'h00000088);
      rd_chk("int_status", `CC_OFF_INTST, 32'h00000004);
      shutdown_in <= 1'b1;
      step(5);
      chk_bit("shutdown_active", 1'b1, shutdown_active);
      @(posedge hclk);
      shutdown_in <= 1'b0;
      step(5);
      rd_chk("status_low", `CC_OFF_STATL, 32'h00000098);
      bus_write(`CC_OFF_STATL, 32'h00000000);
      step(2);
      chk_bit("shutdown_active", 1'b0, shutdown_active);
      rd_chk("status_low", `CC_OFF_STATL, 32'h00000080);
      bus_write(`CC_OFF_INTST, 32'h0000001F);
   endtask
   task automatic t_gate;
      int n;
      bus_write(`CC_OFF_CTRL2H, {24'h0, `CC_GM_FALL, 6'h00});
      bus_write(`CC_OFF_STATL, 32'h00000400);
      rd_chk("status_low", `CC_OFF_STATL, 32'h00000080);
      gate_in <= 1'b0;
      step(5);
      rd_chk("status_low", `CC_OFF_STATL, 32'h00000084);
      cap_pulse(n);
      chk_word("strobes", 32'h0, n);
      bus_write(`CC_OFF_STATL, 32'h00000000);
      cap_pulse(n);
      chk_word("strobes", 32'h1, n);
      cap_rd();
      bus_write(`CC_OFF_INTST, 32'h0000001F);
      // rising-edge mode: disabled from arm until the gate rises
      bus_write(`CC_OFF_CTRL2H, {24'h0, `CC_GM_RISE, 6'h00});
      bus_write(`CC_OFF_STATL, 32'h00000400);
      rd_chk("status_low", `CC_OFF_STATL, 32'h00000084);
      gate_in <= 1'b1;
      step(5);
      rd_chk("status_low", `CC_OFF_STATL, 32'h00000080);
      // off and reserved codes ignore the arm
      for (int m = 0; m < 4; m += 3) begin
         bus_write(`CC_OFF_CTRL2H, 32'(m) << 6);
         bus_write(`CC_OFF_STATL, 32'h00000400);
         gate_in <= 1'b0;
         step(5);
         rd_chk("status_low", `CC_OFF_STATL, 32'h00000080);
         gate_in <= 1'b1;
         step(5);
      end
   endtask
   task automatic t_trigger;
      bus_write(`CC_OFF_CTRL1, 32'h00000080);
      step(2);
      chk_bit("trigger_active", 1'b0, trigger_active);
      rd_chk("status_low", `CC_OFF_STATL, 32'h00000000);
      bus_write(`CC_OFF_STATL, 32'h00000040);
      step(1);
      chk_bit("trigger_active", 1'b1, trigger_active);
      rd_chk("status_low", `CC_OFF_STATL, 32'h00000080);
      bus_write(`CC_OFF_STATL, 32'h00000020);
      step(1);
      chk_bit("trigger_active", 1'b0, trigger_active);
      rd_chk("status_low", `CC_OFF_STATL, 32'h00000000);
      bus_write(`CC_OFF_STATL, 32'h00000060);
      rd_chk("status_low", `CC_OFF_STATL, 32'h00000080);
   endtask
   task automatic t_oneshot;
      int n;
      bus_write(`CC_OFF_PERIOD, 32'h00000003);
      bus_write(`CC_OFF_CTRL1, 32'h000000C0);
      bus_write(`CC_OFF_INTMSK, 32'h00000010);
      for (int c = 0; c < 8; c += (c == 2) ? 5 : 2) begin
         bus_write(`CC_OFF_CTRL3H, 32'(c) << 12);
         bus_write(`CC_OFF_STATL, 32'h00000040);
         n = 0;
         // each extra period of four cycles lengthens the run
         while (trigger_active === 1'b1 || n == 0) begin
            step(1);
            n++;
            if (n > 200) begin
               $display("[FAIL] oneshot_len expected end seen running");
               n_fail++;
               summarize();
            end
         end
         chk_word("oneshot_len", 32'((c + 1) * 4), n);
         step(2);
         chk_bit("irq", 1'b1, irq);
         bus_write(`CC_OFF_INTST, 32'h0000001F);
      end
      bus_write(`CC_OFF_CTRL1, 32'h00000000);
   endtask
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      {capture_in, shutdown_in, compare_match} = '0;
      gate_in = 1'b1;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_capture();
      t_cmp_shut();
      t_gate();
      t_trigger();
      t_oneshot();
      summarize();
   end
endmodule
`default_nettype wire
